// ---- incc_counter.sv ----
// Our own choices: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "incc_map.svh"
// How it works
// RL1: Present count readable as process data.
// RL2: Even type codes count A/B quadrature.
// RL3: Odd type codes: pulses, direction from B.
// RL4: Zero-track fault check off after reset.
// RL5: Shared supply selector, 5/12/24 V, 5 V default.
// RL6: Second channel supply entry has no effect.
// RL7: Supply write needs unlock key first.
// RL8: 1x rising A, 2x both A, 4x A and B.
// RL9: Evaluation defaults to 4-fold.
// RL10: Default range zero to max, high wrap flagged.
// RL11: Max depth 32 bit, compact 16 bit.
// RL12: Down past zero wraps to max, low flag.
// RL13: Software lower/upper bounds confine counting.
// RL14: Bound writes need unlock key.
// RL15: Lower below upper, else reject last write.
// RL16: Up wrap to lower, flag clears past third.
// RL17: Down wrap to upper, clears under two thirds.
// RL18: A leading B counts up, lagging down.
// RL19: Tracks pass two flops before edge logic.
module incc_counter import incc_pkg::*; #(
	parameter int CW = 32
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire incc_track_t tracks_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	output logic [CW-1:0] count_o,
	output logic overflow_o,
	output logic underflow_o,
	output logic zero_fault_o,
	output incc_sup_t supply_sel_o
);
	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic [2:0] mode_r; // Encoder type code
	incc_eval_t eval_r; // Edge evaluation
	logic zero_en_r; // Zero-track fault check enable
	logic compact_r; // Compact image, 16-bit depth
	logic [31:0] key_r; // Unlock key
	logic [CW-1:0] lower_r; // Lower bound
	logic [CW-1:0] upper_r; // Upper bound
	incc_sup_t sup2_r; // Second channel entry, stored only
	logic ack_r;
	logic [31:0] rdat_r;
	logic [CW-1:0] cnt_r;
	logic ovf_r;
	logic unf_r;
	logic zflt_r;
	incc_sup_t sup_r;

	// Bus write strobe; only full-word writes are honoured
	logic wr_req;
	logic unlocked;
	assign wr_req = cyc_i & stb_i & we_i & ~ack_r & (&sel_i);
	assign unlocked = (key_r == `INCC_UNLOCK_KEY);

	// ****************************************************************
	// Pin synchroniser
	// ****************************************************************
	// Two flops per track; a third holds the previous settled value
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] prev_r;
	logic [2:0] fill_r; // Stages holding real pin levels since reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			prev_r <= 4'h0;
			fill_r <= 3'h0;
		end else if (ce_i) begin
			sync1_r <= tracks_i; // RL19
			sync2_r <= sync1_r; // RL19
			prev_r <= sync2_r;
			fill_r <= {fill_r[1:0], 1'b1};
		end
	end
	logic a_s, b_s, a_p, b_p, armed;
	// Until the chain is full the previous stage mirrors the present
	// one, so a track idling high after reset is not taken as an edge
	assign armed = fill_r[2]; // RL19
	assign a_s = sync2_r[3];
	assign b_s = sync2_r[2];
	assign a_p = armed ? prev_r[3] : sync2_r[3]; // RL19
	assign b_p = armed ? prev_r[2] : sync2_r[2]; // RL19

	// ****************************************************************
	// Edge decoder
	// ****************************************************************
	logic a_edge, b_edge, a_rise, quad, step, up;
	assign a_edge = a_s ^ a_p;
	assign b_edge = b_s ^ b_p;
	assign a_rise = a_s & ~a_p;
	assign quad = ~mode_r[0]; // RL2 RL3
	// Step and direction per evaluation
	always_comb begin
		step = 1'b0;
		up = 1'b0;
		if (!quad) begin
			// Pulse input: low B counts up
			up = ~b_s; // RL3
			step = (eval_r == EV_X1) ? a_rise : a_edge; // RL8
		end else begin
			unique case (eval_r)
				EV_X1: begin
					step = a_rise; // RL8
					up = ~b_s; // RL18
				end
				EV_X2: begin
					step = a_edge; // RL8
					up = a_s ^ b_s; // RL18
				end
				default: begin
					// Both tracks moving at once is a lost state
					step = a_edge ^ b_edge; // RL8
					up = a_s ^ b_p; // RL18
				end
			endcase
		end
	end

	// ****************************************************************
	// Range and flag thresholds
	// ****************************************************************
	logic [CW-1:0] hi, lo, span, thr_lo, thr_hi;
	logic [CW:0] span2;
	always_comb begin
		// Compact image caps the depth at 16 bits
		hi = upper_r; // RL13
		if (compact_r && upper_r > CW'(`INCC_MAX_CMPT))
			hi = CW'(`INCC_MAX_CMPT); // RL11
		lo = (lower_r < hi) ? lower_r : '0;
		span = hi - lo;
		span2 = {span, 1'b0};
		thr_lo = lo + span / CW'(3); // RL16
		thr_hi = lo + CW'(span2 / (CW+1)'(3)); // RL17
	end

	// ****************************************************************
	// Counter and wrap flags
	// ****************************************************************
	// Counter with wraparound at the bounds
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= '0;
		end else if (ce_i && step) begin
			if (up)
				cnt_r <= (cnt_r == hi) ? lo : cnt_r + CW'(1); // RL10 RL16
			else
				cnt_r <= (cnt_r == lo) ? hi : cnt_r - CW'(1); // RL12 RL17
		end
	end
	// High wrap flag; setting wins over the clearing threshold
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ovf_r <= 1'b0;
		else if (ce_i) begin
			if (step && up && cnt_r == hi)
				ovf_r <= 1'b1; // RL10 RL16
			else if (cnt_r > thr_lo)
				ovf_r <= 1'b0; // RL16
		end
	end
	// Low wrap flag; setting wins over the clearing threshold
	always_ff @(posedge clk_i) begin
		if (rst_i)
			unf_r <= 1'b0;
		else if (ce_i) begin
			if (step && !up && cnt_r == lo)
				unf_r <= 1'b1; // RL12 RL17
			else if (cnt_r < thr_hi)
				unf_r <= 1'b0; // RL17
		end
	end
	// Zero-track fault follows the receiver only when enabled
	always_ff @(posedge clk_i) begin
		if (rst_i)
			zflt_r <= 1'b0;
		else if (ce_i)
			zflt_r <= zero_en_r & sync2_r[0]; // RL4
	end

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// Control word is never locked
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_r <= 3'h0;
			eval_r <= EV_X4; // RL9
			zero_en_r <= 1'b0; // RL4
			compact_r <= 1'b0;
		end else if (ce_i && wr_req && adr_i == `INCC_REG_CTRL) begin
			mode_r <= dat_i[`INCC_CTRL_MODE_LSB +: 3];
			eval_r <= (dat_i[`INCC_CTRL_EVAL_LSB +: 2] == 2'h3) ? EV_X4 :
				incc_eval_t'(dat_i[`INCC_CTRL_EVAL_LSB +: 2]);
			zero_en_r <= dat_i[`INCC_CTRL_ZEN_BIT]; // RL4
			compact_r <= dat_i[`INCC_CTRL_CMPT_BIT]; // RL11
		end
	end
	// Key stays until overwritten or reset
	always_ff @(posedge clk_i) begin
		if (rst_i)
			key_r <= 32'h00000000;
		else if (ce_i && wr_req && adr_i == `INCC_REG_KEY)
			key_r <= dat_i;
	end
	// Bounds: locked, and a write breaking the order is dropped
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lower_r <= CW'(`INCC_RST_LOWER);
			upper_r <= CW'(`INCC_RST_UPPER);
		end else if (ce_i && wr_req && unlocked) begin // RL14
			if (adr_i == `INCC_REG_LOWER && CW'(dat_i) < upper_r)
				lower_r <= CW'(dat_i); // RL13 RL15
			if (adr_i == `INCC_REG_UPPER && CW'(dat_i) > lower_r)
				upper_r <= CW'(dat_i); // RL13 RL15
		end
	end
	// Supply level; only the first entry drives the selector
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sup_r <= SUP_5V; // RL5
			sup2_r <= SUP_5V;
		end else if (ce_i && wr_req && unlocked && dat_i[1:0] != 2'h3) begin
			if (adr_i == `INCC_REG_SUP1)
				sup_r <= incc_sup_t'(dat_i[1:0]); // RL5 RL7
			if (adr_i == `INCC_REG_SUP2)
				sup2_r <= incc_sup_t'(dat_i[1:0]); // RL6
		end
	end

	// ****************************************************************
	// Bus answer
	// ****************************************************************
	// One-cycle acknowledge, unmapped reads return zero
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h00000000;
		end else if (ce_i) begin
			ack_r <= cyc_i & stb_i & ~ack_r;
			unique case (adr_i)
				`INCC_REG_CTRL: rdat_r <= {22'h000000, compact_r,
					zero_en_r, 2'h0, eval_r, 1'b0, mode_r};
				`INCC_REG_STAT: rdat_r <= {28'h0000000, b_s, zflt_r,
					ovf_r, unf_r};
				`INCC_REG_COUNT: rdat_r <= 32'(cnt_r); // RL1
				`INCC_REG_LOWER: rdat_r <= 32'(lower_r);
				`INCC_REG_UPPER: rdat_r <= 32'(upper_r);
				`INCC_REG_KEY: rdat_r <= key_r;
				`INCC_REG_SUP1: rdat_r <= {30'h00000000, sup_r};
				`INCC_REG_SUP2: rdat_r <= {30'h00000000, sup2_r};
				default: rdat_r <= 32'h00000000;
			endcase
		end
	end
	assign dat_o = rdat_r;
	assign ack_o = ack_r;
	assign count_o = cnt_r; // RL1
	assign overflow_o = ovf_r;
	assign underflow_o = unf_r;
	assign zero_fault_o = zflt_r;
	assign supply_sel_o = sup_r;

	// ****************************************************************
	// Checks
	// ****************************************************************
	chk_wrap_high: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
		ce_i && step && up && cnt_r == hi |=> cnt_r == $past(lo) && ovf_r)
		else $error("high wrap wrong");
	chk_wrap_low: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
		ce_i && step && !up && cnt_r == lo |=> cnt_r == $past(hi) && unf_r)
		else $error("low wrap wrong");
	chk_one_fold: assert property (@(posedge clk_i) disable iff (rst_i) // RL8
		ce_i && eval_r == EV_X1 && !a_rise |=> $stable(cnt_r))
		else $error("1-fold counted a non-rising edge");
	chk_quad_up: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
		ce_i && quad && eval_r == EV_X4 && a_rise && !b_s && !b_p
		&& cnt_r != hi |=> cnt_r == $past(cnt_r) + CW'(1))
		else $error("A leading B did not count up");
	chk_pulse_dir: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
		ce_i && !quad && a_rise && b_s && cnt_r != lo
		|=> cnt_r == $past(cnt_r) - CW'(1))
		else $error("high B did not count down");
	chk_supply_lock: assert property (@(posedge clk_i) disable iff (rst_i) // RL7
		wr_req && !unlocked |=> $stable(supply_sel_o))
		else $error("supply changed while locked");
	chk_ch2_inert: assert property (@(posedge clk_i) disable iff (rst_i) // RL6
		wr_req && adr_i == `INCC_REG_SUP2 |=> $stable(supply_sel_o))
		else $error("second entry moved supply");
	chk_bound_lock: assert property (@(posedge clk_i) disable iff (rst_i) // RL14
		wr_req && !unlocked |=> $stable(lower_r) && $stable(upper_r))
		else $error("bound changed while locked");
	chk_bound_order: assert property (@(posedge clk_i) disable iff (rst_i) // RL15
		lower_r < upper_r)
		else $error("lower bound not below upper");
	chk_reset_dflt: assert property (@(posedge clk_i) // RL9
		rst_i |=> eval_r == EV_X4 && supply_sel_o == SUP_5V && !zero_en_r)
		else $error("reset defaults wrong");
	chk_zero_off: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
		!zero_en_r && $past(!zero_en_r) && $past(ce_i) |-> !zero_fault_o)
		else $error("zero fault while disabled");
	chk_bus_ack: assert property (@(posedge clk_i) disable iff (rst_i)
		ce_i && cyc_i && stb_i && !ack_o
		|=> ack_o ##1 (!ack_o || !$past(ce_i)))
		else $error("acknowledge not one cycle");
endmodule : incc_counter

// ---- incc_map.svh ----
`ifndef INCC_MAP_SVH
`define INCC_MAP_SVH
// ****************************************************************
// Register byte offsets
// ****************************************************************
`define INCC_REG_CTRL 8'h00
`define INCC_REG_STAT 8'h04
`define INCC_REG_COUNT 8'h08
`define INCC_REG_LOWER 8'h0C
`define INCC_REG_UPPER 8'h10
`define INCC_REG_KEY 8'h14
`define INCC_REG_SUP1 8'h18
`define INCC_REG_SUP2 8'h1C
// ****************************************************************
// Control field positions
// ****************************************************************
`define INCC_CTRL_MODE_LSB 0
`define INCC_CTRL_EVAL_LSB 4
`define INCC_CTRL_ZEN_BIT 8
`define INCC_CTRL_CMPT_BIT 9
// ****************************************************************
// Reset values, unlock word and compact maximum
// ****************************************************************
`define INCC_UNLOCK_KEY 32'h72657375
`define INCC_RST_LOWER 32'h00000000
`define INCC_RST_UPPER 32'hFFFFFFFF
`define INCC_MAX_CMPT 32'h0000FFFF
`endif

// ---- incc_pkg.sv ----
// ****************************************************************
// Shared types of the position counter
// ****************************************************************
package incc_pkg;
	// Edge evaluation; first member is the reset value
	typedef enum logic [1:0] {EV_X4, EV_X2, EV_X1} incc_eval_t;
	// Sensor supply level; first member is the reset value
	typedef enum logic [1:0] {SUP_5V, SUP_12V, SUP_24V} incc_sup_t;
	// Encoder tracks as they arrive on the pins
	typedef struct packed {
		logic a; // Track A
		logic b; // Track B
		logic c; // Zero pulse track
		logic c_fault; // Zero track receiver fault
	} incc_track_t;
endpackage : incc_pkg

// ---- incc_enc_model.sv ----
`timescale 1ns/1ps
// ****************************************
// Encoder or pulse source on the far side
// ****************************************
module incc_enc_model import incc_pkg::*; (
	input wire logic clk_i,
	input wire logic step_i,
	input wire logic up_i,
	input wire logic pulse_i,
	input wire logic fault_i,
	output incc_track_t tracks_o
);
	logic a_r = 1'b0; // Track A level
	logic b_r = 1'b0; // Track B level
	// One step a request; only one track moves in quadrature,
	// so no step ever looks like a simultaneous change
	always @(posedge clk_i) begin
		// Direction level settles ahead of the pulse, never with it
		if (pulse_i)
			b_r <= ~up_i;
		if (step_i) begin
			if (pulse_i) begin
				a_r <= ~a_r;
			end else if ((a_r == b_r) == up_i) begin
				a_r <= ~a_r;
			end else begin
				b_r <= ~b_r;
			end
		end
	end
	// Zero track stays quiet; its fault line is commanded
	assign tracks_o = '{a: a_r, b: b_r, c: 1'b0, c_fault: fault_i};
endmodule : incc_enc_model

// ---- incc_counter_test.sv ----
`timescale 1ns/1ps
`include "incc_map.svh"
module incc_counter_test import incc_pkg::*;;
	logic clk_i = 1'b0; // Bench clock
	logic rst_i = 1'b1; // Reset, held at start
	logic ce = 1'b1; // Clock enable to the block
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0; // Bus strobes
	logic [7:0] adr = 8'h00; // Bus address
	logic [31:0] dat = 32'h00000000, q, dat_o; // Bus data
	logic [3:0] sel = 4'h0; // Byte selects
	logic step = 1'b0, up = 1'b0, pulse = 1'b0, fault = 1'b0;
	logic ack_o, overflow_o, underflow_o, zero_fault_o;
	logic [31:0] count_o; // Present count
	incc_track_t trk; // Pins from the encoder
	incc_sup_t supply_sel_o; // Supply level out
	int num_errors = 0, checked = 0;
	always #20 clk_i = ~clk_i;
	incc_enc_model partner (.clk_i(clk_i), .step_i(step), .up_i(up),
		.pulse_i(pulse), .fault_i(fault), .tracks_o(trk));
	incc_counter #(.CW(32)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.ce_i(ce), .tracks_i(trk), .cyc_i(cyc), .stb_i(stb),
		.we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o),
		.ack_o(ack_o), .count_o(count_o), .overflow_o(overflow_o),
		.underflow_o(underflow_o), .zero_fault_o(zero_fault_o),
		.supply_sel_o(supply_sel_o));
	// ****************************************
	// Bus, compare and stepping tasks
	// ****************************************
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk
	// Classic cycle; holds until ack, wait bounded by watchdog
	task automatic wb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		sel <= 4'hF;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask : wb
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h00000000);
		chk(q, exp);
	endtask : rd
	// Steps spaced well past the four-edge count latency
	task automatic mv(input logic u, input int n);
		up <= u;
		repeat (2) @(posedge clk_i);
		repeat (n) begin
			step <= 1'b1;
			@(posedge clk_i);
			step <= 1'b0;
			repeat (7) @(posedge clk_i);
		end
	endtask : mv
	task automatic close_out;
		$display("errors %0d checks %0d", num_errors, checked);
		if (num_errors == 0 && checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : close_out
	// Watchdog: far beyond the few hundred cycles needed
	initial begin
		repeat (20000) @(posedge clk_i);
		num_errors++;
		close_out();
	end
	// ****************************************
	// Test sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`INCC_REG_CTRL, 32'h00000000);
		rd(`INCC_REG_UPPER, `INCC_RST_UPPER);
		rd(8'h40, 32'h00000000);
		chk(supply_sel_o, SUP_5V);
		mv(1'b1, 3);
		rd(`INCC_REG_COUNT, 32'h00000003);
		// Clock enable low: the pin edge waits until it returns
		ce <= 1'b0;
		mv(1'b1, 1);
		chk(count_o, 32'h00000003);
		ce <= 1'b1;
		repeat (6) @(posedge clk_i);
		chk(count_o, 32'h00000004);
		mv(1'b0, 5);
		chk(count_o, 32'hFFFFFFFF);
		chk(underflow_o, 1'b1);
		rd(`INCC_REG_STAT, 32'h00000009);
		mv(1'b1, 1);
		chk(count_o, 32'h00000000);
		chk(overflow_o, 1'b1);
		wb(1'b1, `INCC_REG_CTRL, 32'h00000200);
		mv(1'b0, 1);
		chk(count_o, `INCC_MAX_CMPT);
		// Two-fold, then one-fold, on the other quadrature codes
		wb(1'b1, `INCC_REG_CTRL, 32'h00000012);
		mv(1'b1, 4);
		chk(count_o, 32'h00010001);
		wb(1'b1, `INCC_REG_CTRL, 32'h00000024);
		mv(1'b1, 4);
		chk(count_o, 32'h00010002);
		// Pulse codes: two up, one down each
		for (int m = 1; m < 6; m += 2) begin
			wb(1'b1, `INCC_REG_CTRL, m);
			pulse <= 1'b1;
			mv(1'b1, 2);
			mv(1'b0, 1);
			chk(count_o, 32'h00010003 + (m >> 1));
		end
		// Evaluation code 3 falls back to four-fold
		wb(1'b1, `INCC_REG_CTRL, 32'h00000035);
		rd(`INCC_REG_CTRL, 32'h00000005);
		// Long enough for the fault to reach the flag if ungated
		fault <= 1'b1;
		repeat (4) @(posedge clk_i);
		chk(zero_fault_o, 1'b0);
		wb(1'b1, `INCC_REG_CTRL, 32'h00000100);
		pulse <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk(zero_fault_o, 1'b1);
		// Second reset mid-run, then the locked settings
		rst_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		fault <= 1'b0;
		chk(zero_fault_o, 1'b0);
		wb(1'b1, `INCC_REG_LOWER, 32'h00000005);
		rd(`INCC_REG_LOWER, 32'h00000000);
		wb(1'b1, `INCC_REG_SUP1, 32'h00000001);
		chk(supply_sel_o, SUP_5V);
		wb(1'b1, `INCC_REG_KEY, `INCC_UNLOCK_KEY);
		wb(1'b1, `INCC_REG_SUP1, 32'h00000001);
		chk(supply_sel_o, SUP_12V);
		wb(1'b1, `INCC_REG_SUP1, 32'h00000003);
		chk(supply_sel_o, SUP_12V);
		wb(1'b1, `INCC_REG_SUP1, 32'h00000002);
		wb(1'b1, `INCC_REG_SUP2, 32'h00000001);
		chk(supply_sel_o, SUP_24V);
		rd(`INCC_REG_SUP2, 32'h00000001);
		wb(1'b1, `INCC_REG_UPPER, 32'h00000008);
		wb(1'b1, `INCC_REG_LOWER, 32'h00000009);
		rd(`INCC_REG_UPPER, 32'h00000008);
		rd(`INCC_REG_LOWER, 32'h00000000);
		// Range 0..8: flags clear at 3 going up, at 4 going down
		mv(1'b1, 9);
		chk(count_o, 32'h00000000);
		mv(1'b1, 2);
		chk(overflow_o, 1'b1);
		mv(1'b1, 1);
		chk(overflow_o, 1'b0);
		mv(1'b0, 4);
		chk(count_o, 32'h00000008);
		mv(1'b0, 3);
		chk(underflow_o, 1'b1);
		mv(1'b0, 1);
		chk(underflow_o, 1'b0);
		close_out();
	end
endmodule : incc_counter_test
